/* core/txpc_pkg.sv */
// constants and types shared by the transmitter power control loop
// What this block does
// [R1] The commanded inverter input voltage stays between 2 V and 12 V, in 0.5 mV steps.
// [R2] The commanded operating frequency stays between 110 kHz and 205 kHz.
// [R3] The commanded duty cycle stays between 2 % and 50 %.
// [R4] A ping starts at 125 kHz and an input voltage between 3.5 V and 7.5 V.
// [R5] When no signal strength packet follows a ping, the power signal is removed.
// [R6] Pings repeat at rising input voltage until an acceptable signal strength arrives; the code gives up after the 7.5 V ping and sets ping_fail.
// [R7] During transfer a PID loop drives voltage, frequency and duty cycle.
// [R8] Power is adjusted mainly through the input voltage.
// [R9] The coil current amplitude is taken in 1 mA units, finer than 5 mA.
// [R10] Voltage loop: gain 1, no I or D term, output limit 1500, scaling -0.5 mV.
// [R11] Frequency loop: gain 1, no I or D term, output limit 20000, scaling 1.0 Hz.
// [R12] Duty loop: gain 1, no I or D term, output limit 20000, scaling -0.1 %.
// [R13] Every actuator target is clamped to its range after each loop update.
// [R14] Corrections go to the voltage first, and to frequency or duty only at a voltage limit.
`default_nettype none
package txpc_pkg;
  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PING_WAIT_US = 65000; // wait for signal strength after ping start
  localparam int PING_GAP_US = 100000; // power-off gap before a retry
  localparam int PING_WAIT_CYC_DEF = PING_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int PING_GAP_CYC_DEF = PING_GAP_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // actuator widths and units
  // ---------------------------------------------------------------------
  localparam int VIN_W = 15; // input voltage, 0.5 mV per code
  localparam int FRQ_W = 18; // frequency, 1 Hz per code
  localparam int DTY_W = 9; // duty cycle, 0.1 % per code
  localparam int DLT_W = 17; // signed loop output
  localparam int CUR_W = 16; // coil current, 1 mA per code

  // voltage codes: half millivolt steps so the -0.5 mV scaling is exact
  localparam logic [VIN_W-1:0] VIN_MIN = 15'h0FA0; // 2.0 V
  localparam logic [VIN_W-1:0] VIN_MAX = 15'h5DC0; // 12.0 V
  localparam logic [VIN_W-1:0] PING_VIN_START = 15'h1B58; // 3.5 V
  localparam logic [VIN_W-1:0] PING_VIN_LAST = 15'h3A98; // 7.5 V
  localparam logic [VIN_W-1:0] PING_VIN_STEP = 15'h03E8; // 0.5 V per retry

  localparam logic [FRQ_W-1:0] FRQ_MIN = 18'h1ADB0; // 110 kHz
  localparam logic [FRQ_W-1:0] FRQ_MAX = 18'h320C8; // 205 kHz
  localparam logic [FRQ_W-1:0] PING_FRQ = 18'h1E848; // 125 kHz

  localparam logic [DTY_W-1:0] DTY_MIN = 9'h014; // 2 %
  localparam logic [DTY_W-1:0] DTY_MAX = 9'h1F4; // 50 %
  localparam logic [DTY_W-1:0] PING_DTY = 9'h1F4; // full 50 % during ping

  // loop output limits
  localparam logic [DLT_W-1:0] VIN_PID_LIM = 17'h005DC; // 1500
  localparam logic [DLT_W-1:0] FRQ_PID_LIM = 17'h04E20; // 20000
  localparam logic [DLT_W-1:0] DTY_PID_LIM = 17'h04E20; // 20000

  localparam logic [7:0] SS_MIN_DEF = 8'h01; // least acceptable signal strength

  typedef enum logic [1:0] {
    TXPC_IDLE,
    TXPC_PING,
    TXPC_GAP,
    TXPC_XFER
  } txpc_state_t;
endpackage
`default_nettype wire

/* core/txpc_step_clamp.sv */
// one actuator: adds a signed step and clamps the result to its range
`default_nettype none
module txpc_step_clamp #(
  parameter int W = 15
) (
  input wire logic [W-1:0] cur,
  input wire logic signed [txpc_pkg::DLT_W-1:0] delta,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  output logic [W-1:0] next,
  output logic clipped
);
  localparam int SW = 21; // wide enough for any width here plus the step

  logic signed [SW-1:0] sum;
  logic below;
  logic above;

  // ---------------------------------------------------------------------
  // add and clamp
  // ---------------------------------------------------------------------
  assign sum = $signed({{(SW-W){1'b0}}, cur}) + SW'(delta);
  assign below = sum < $signed({{(SW-W){1'b0}}, lo});
  assign above = sum > $signed({{(SW-W){1'b0}}, hi});
  // clipped also reports a step that pushes further into a limit already held
  assign clipped = below || above;
  assign next = below ? lo : (above ? hi : sum[W-1:0]); // R13
endmodule
`default_nettype wire

/* core/txpc_loop.sv */
// ping sequencing and proportional power loop for a full-bridge transmitter
`default_nettype none
module txpc_loop #(
  parameter int unsigned PING_WAIT_CYC = txpc_pkg::PING_WAIT_CYC_DEF,
  parameter int unsigned PING_GAP_CYC = txpc_pkg::PING_GAP_CYC_DEF,
  parameter logic [7:0] SS_MIN = txpc_pkg::SS_MIN_DEF,
  parameter int PROP_GAIN = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic stop,
  input wire logic ss_valid,
  input wire logic [7:0] ss_value,
  input wire logic ctrl_valid,
  input wire logic [txpc_pkg::CUR_W-1:0] target_ma,
  input wire logic [txpc_pkg::CUR_W-1:0] coil_ma,
  output logic power_en,
  output logic [txpc_pkg::VIN_W-1:0] vin_code,
  output logic [txpc_pkg::FRQ_W-1:0] freq_hz,
  output logic [txpc_pkg::DTY_W-1:0] duty_code,
  output logic xfer_active,
  output logic ping_fail
);
  localparam int DW = txpc_pkg::DLT_W;

  txpc_pkg::txpc_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [txpc_pkg::VIN_W-1:0] vin_reg, vin_next;
  logic [txpc_pkg::FRQ_W-1:0] frq_reg, frq_next;
  logic [txpc_pkg::DTY_W-1:0] dty_reg, dty_next;
  logic fail_reg, fail_next;

  // ---------------------------------------------------------------------
  // loop error and per-actuator limited outputs
  // ---------------------------------------------------------------------
  logic signed [DW-1:0] err;
  logic signed [DW-1:0] pterm;
  logic signed [DW-1:0] v_pid, f_pid, d_pid;
  logic signed [DW-1:0] v_dlt, f_dlt, d_dlt;

  // error in 1 mA units, well below the 5 mA resolution bound
  assign err = $signed({1'b0, target_ma}) - $signed({1'b0, coil_ma}); // R9
  // integral and derivative gains are zero, so only the P term remains
  assign pterm = DW'(err * PROP_GAIN); // R7
  assign v_pid = (pterm > $signed(txpc_pkg::VIN_PID_LIM)) ? $signed(txpc_pkg::VIN_PID_LIM) :
                 (pterm < -$signed(txpc_pkg::VIN_PID_LIM)) ? -$signed(txpc_pkg::VIN_PID_LIM) :
                 pterm; // R10
  assign f_pid = (pterm > $signed(txpc_pkg::FRQ_PID_LIM)) ? $signed(txpc_pkg::FRQ_PID_LIM) :
                 (pterm < -$signed(txpc_pkg::FRQ_PID_LIM)) ? -$signed(txpc_pkg::FRQ_PID_LIM) :
                 pterm; // R11
  assign d_pid = (pterm > $signed(txpc_pkg::DTY_PID_LIM)) ? $signed(txpc_pkg::DTY_PID_LIM) :
                 (pterm < -$signed(txpc_pkg::DTY_PID_LIM)) ? -$signed(txpc_pkg::DTY_PID_LIM) :
                 pterm; // R12
  // new = old - scaling * pid; scaling -0.5 mV is one code up per unit
  assign v_dlt = v_pid; // R10
  // scaling +1 Hz: more current wanted means lower frequency
  assign f_dlt = -f_pid; // R11
  // scaling -0.1 %: one duty code up per unit
  assign d_dlt = d_pid; // R12

  // ---------------------------------------------------------------------
  // clamped candidate targets
  // ---------------------------------------------------------------------
  logic [txpc_pkg::VIN_W-1:0] vin_cand;
  logic [txpc_pkg::FRQ_W-1:0] frq_cand;
  logic [txpc_pkg::DTY_W-1:0] dty_cand;
  logic v_clip, f_clip;

  txpc_step_clamp #(.W(txpc_pkg::VIN_W)) u_vin (
    .cur(vin_reg), .delta(v_dlt), .lo(txpc_pkg::VIN_MIN), .hi(txpc_pkg::VIN_MAX),
    .next(vin_cand), .clipped(v_clip) // R1
  );
  txpc_step_clamp #(.W(txpc_pkg::FRQ_W)) u_frq (
    .cur(frq_reg), .delta(f_dlt), .lo(txpc_pkg::FRQ_MIN), .hi(txpc_pkg::FRQ_MAX),
    .next(frq_cand), .clipped(f_clip) // R2
  );
  txpc_step_clamp #(.W(txpc_pkg::DTY_W)) u_dty (
    .cur(dty_reg), .delta(d_dlt), .lo(txpc_pkg::DTY_MIN), .hi(txpc_pkg::DTY_MAX),
    .next(dty_cand), .clipped() // R3
  );

  // ---------------------------------------------------------------------
  // decode of events
  // ---------------------------------------------------------------------
  wire in_ping = state_reg == txpc_pkg::TXPC_PING;
  wire in_xfer = state_reg == txpc_pkg::TXPC_XFER;
  wire ss_good = ss_valid && (ss_value >= SS_MIN);
  wire ping_timeout = in_ping && !ss_good && (cnt_reg >= PING_WAIT_CYC - 1);
  wire ping_reject = in_ping && ss_valid && !ss_good;
  wire gap_done = (state_reg == txpc_pkg::TXPC_GAP) && (cnt_reg >= PING_GAP_CYC - 1);
  wire vin_exhausted = (vin_reg + txpc_pkg::PING_VIN_STEP) > txpc_pkg::PING_VIN_LAST;
  wire loop_upd = in_xfer && ctrl_valid && !stop;

  // ---------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 32'h00000001;
    vin_next = vin_reg;
    frq_next = frq_reg;
    dty_next = dty_reg;
    fail_next = fail_reg;
    unique case (state_reg)
      txpc_pkg::TXPC_IDLE: begin
        cnt_next = 32'h00000000;
        if (start) begin
          state_next = txpc_pkg::TXPC_PING;
          vin_next = txpc_pkg::PING_VIN_START; // R4
          frq_next = txpc_pkg::PING_FRQ; // R4
          dty_next = txpc_pkg::PING_DTY;
          fail_next = 1'b0;
        end
      end
      txpc_pkg::TXPC_PING: begin
        if (ss_good) begin
          state_next = txpc_pkg::TXPC_XFER;
          cnt_next = 32'h00000000;
        end else if (ping_timeout || ping_reject) begin
          // power is withdrawn first; the retry comes after the gap
          cnt_next = 32'h00000000;
          if (vin_exhausted) begin
            state_next = txpc_pkg::TXPC_IDLE; // R5
            fail_next = 1'b1;
          end else begin
            state_next = txpc_pkg::TXPC_GAP; // R5
          end
        end
      end
      txpc_pkg::TXPC_GAP: begin
        if (gap_done) begin
          state_next = txpc_pkg::TXPC_PING;
          cnt_next = 32'h00000000;
          vin_next = vin_reg + txpc_pkg::PING_VIN_STEP; // R6
        end
      end
      txpc_pkg::TXPC_XFER: begin
        cnt_next = 32'h00000000;
        if (stop) begin
          state_next = txpc_pkg::TXPC_IDLE;
        end else if (loop_upd) begin
          vin_next = vin_cand; // R8 R13
          // voltage pinned: spill into frequency, then into duty
          if (v_clip) begin
            if (!f_clip) begin
              frq_next = frq_cand; // R14
            end else begin
              frq_next = frq_cand; // R13
              dty_next = dty_cand; // R14
            end
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= txpc_pkg::TXPC_IDLE;
      cnt_reg <= 32'h00000000;
      vin_reg <= txpc_pkg::PING_VIN_START;
      frq_reg <= txpc_pkg::PING_FRQ;
      dty_reg <= txpc_pkg::PING_DTY;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      vin_reg <= vin_next;
      frq_reg <= frq_next;
      dty_reg <= dty_next;
      fail_reg <= fail_next;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // the bridge is only on while pinging or transferring
  assign power_en = in_ping || in_xfer; // R5
  assign vin_code = vin_reg;
  assign freq_hz = frq_reg;
  assign duty_code = dty_reg;
  assign xfer_active = in_xfer;
  assign ping_fail = fail_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_ping_entry;
    state_reg == txpc_pkg::TXPC_IDLE && start;
  endsequence
  sequence s_ping_drive;
    power_en && freq_hz == txpc_pkg::PING_FRQ && vin_code == txpc_pkg::PING_VIN_START;
  endsequence

  a_vin_range: assert property (vin_code >= txpc_pkg::VIN_MIN && vin_code <= txpc_pkg::VIN_MAX) // R1
    else $error("input voltage target out of range");
  a_freq_range: assert property (freq_hz >= txpc_pkg::FRQ_MIN && freq_hz <= txpc_pkg::FRQ_MAX) // R2
    else $error("frequency target out of range");
  a_duty_range: assert property (duty_code >= txpc_pkg::DTY_MIN && duty_code <= txpc_pkg::DTY_MAX) // R3
    else $error("duty target out of range");
  a_ping_start: assert property (s_ping_entry |=> s_ping_drive) // R4
    else $error("ping did not start at its initial operating point");
  a_ping_vin_win: assert property (in_ping |-> vin_code >= txpc_pkg::PING_VIN_START &&
                                   vin_code <= txpc_pkg::PING_VIN_LAST) // R4
    else $error("ping voltage outside its window");
  a_ping_removed: assert property (ping_timeout |=> !power_en) // R5
    else $error("power signal kept after missing signal strength");
  a_retry_higher: assert property (gap_done |=> in_ping &&
                                   vin_code == $past(vin_code) + txpc_pkg::PING_VIN_STEP) // R6
    else $error("retry ping not one step higher");
  a_ss_to_xfer: assert property (in_ping && ss_good |=> xfer_active ##0 $stable(vin_code)) // R7
    else $error("good signal strength did not start transfer");
  a_volt_first: assert property (loop_upd && !v_clip |=> $stable(freq_hz) && $stable(duty_code)) // R14
    else $error("frequency or duty moved while voltage had room");
  a_volt_step: assert property (loop_upd && !v_clip && v_pid > 0 |=> vin_code > $past(vin_code)) // R10
    else $error("voltage did not rise for positive error");
  // a weak reply is handled like a missing one: the bridge goes off before any retry
  a_weak_ss_off: assert property (ping_reject |=> !power_en) // R6
    else $error("power signal kept after a weak signal strength");
  a_duty_last: assert property (loop_upd && !(v_clip && f_clip) |=> $stable(duty_code)) // R14
    else $error("duty moved before voltage and frequency were pinned");
endmodule
`default_nettype wire

/* sim/txpc_rx_model.sv */
// receiver model: answers pings with signal strength and sends loop update packets
`default_nettype none
module txpc_rx_model (
  input wire logic mclk,
  input wire logic power_en,
  input wire logic answer_en,
  input wire logic [7:0] answer_val,
  output var logic ss_valid,
  output var logic [7:0] ss_value,
  output var logic ctrl_valid,
  output var logic [txpc_pkg::CUR_W-1:0] target_ma,
  output var logic [txpc_pkg::CUR_W-1:0] coil_ma
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] on_cnt;
  // ----------------------------------------
  // signal strength reply
  // ----------------------------------------
  initial begin
    on_cnt = 8'h00;
    ss_valid = 1'b0;
    ss_value = 8'h00;
    ctrl_valid = 1'b0;
    target_ma = 16'h0000;
    coil_ma = 16'h0000;
  end
  // one packet a few cycles into each carrier burst; an idle line toggles so stale data never matches
  always @(negedge mclk) begin
    if (power_en !== 1'b1) begin
      on_cnt <= 8'h00;
    end else if (on_cnt != 8'hFF) begin
      on_cnt <= on_cnt + 8'h01;
    end
    ss_valid <= answer_en && power_en === 1'b1 && on_cnt == 8'h04;
    ss_value <= (answer_en && on_cnt == 8'h04) ? answer_val : ~ss_value;
  end
  // one loop update; values are held across the taking edge, then scrambled
  task automatic send_ctrl(input logic [15:0] tgt, input logic [15:0] meas);
    @(negedge mclk);
    ctrl_valid = 1'b1;
    target_ma = tgt;
    coil_ma = meas;
    @(negedge mclk);
    ctrl_valid = 1'b0;
    target_ma = ~tgt;
    coil_ma = ~meas;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the transmitter power control loop
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic mclk, sys_rst, start, stop, answer_en, ss_valid, ctrl_valid;
  logic power_en, xfer_active, ping_fail;
  logic [7:0] answer_val, ss_value;
  logic [txpc_pkg::CUR_W-1:0] target_ma, coil_ma;
  logic [txpc_pkg::VIN_W-1:0] vin_code;
  logic [txpc_pkg::FRQ_W-1:0] freq_hz;
  logic [txpc_pkg::DTY_W-1:0] duty_code;
  int fail_count = 0;
  int compares = 0;
  // short ping counts keep the whole retry ladder to a few hundred cycles
  txpc_loop #(.PING_WAIT_CYC(20), .PING_GAP_CYC(10)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .start(start), .stop(stop), .ss_valid(ss_valid), .ss_value(ss_value),
    .ctrl_valid(ctrl_valid), .target_ma(target_ma), .coil_ma(coil_ma), .power_en(power_en),
    .vin_code(vin_code), .freq_hz(freq_hz), .duty_code(duty_code),
    .xfer_active(xfer_active), .ping_fail(ping_fail));
  txpc_rx_model rx_u (.mclk(mclk), .power_en(power_en), .answer_en(answer_en),
    .answer_val(answer_val), .ss_valid(ss_valid), .ss_value(ss_value),
    .ctrl_valid(ctrl_valid), .target_ma(target_ma), .coil_ma(coil_ma));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic kick();
    @(negedge mclk);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask
  task automatic push(input int n, input logic [15:0] tgt, input logic [15:0] meas);
    repeat (n) rx_u.send_ctrl(tgt, meas);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(power_en, 1'b0);
    check(xfer_active, 1'b0);
    check(ping_fail, 1'b0);
    check(vin_code, 15'h1B58);
    check(freq_hz, 18'h1E848);
    check(duty_code, 9'h1F4);
    $display("test reset done");
  endtask
  // ping, accept, then walk the voltage to both limits so frequency and duty take over
  task automatic t_xfer();
    kick();
    check(power_en, 1'b1);
    check(freq_hz, 18'h1E848);
    check(vin_code, 15'h1B58);
    repeat (40) if (xfer_active !== 1'b1) @(negedge mclk);
    check(xfer_active, 1'b1);
    rx_u.send_ctrl(16'h04B0, 16'h03E8);
    check(vin_code, 15'h1C20);
    check(freq_hz, 18'h1E848);
    rx_u.send_ctrl(16'h0000, 16'h1388);
    check(vin_code, 15'h1644);
    push(12, 16'h0BB8, 16'h0000);
    check(vin_code, 15'h5C94);
    check(freq_hz, 18'h1E848);
    push(1, 16'h0BB8, 16'h0000);
    check(vin_code, 15'h5DC0);
    check(freq_hz, 18'h1DC90);
    push(1, 16'h7530, 16'h0000);
    check(freq_hz, 18'h1ADB0);
    check(duty_code, 9'h1F4);
    push(13, 16'h0000, 16'h05DC);
    check(vin_code, 15'h1194);
    check(freq_hz, 18'h1ADB0);
    push(1, 16'h0000, 16'h01F4);
    check(vin_code, 15'h0FA0);
    push(1, 16'h0000, 16'h4E20);
    check(freq_hz, 18'h1FBD0);
    check(duty_code, 9'h1F4);
    push(4, 16'h0000, 16'h4E20);
    check(freq_hz, 18'h320C8);
    check(duty_code, 9'h014);
    $display("test loop done");
  endtask
  // stop wins over an update in the same cycle, and a later packet must not move the targets
  task automatic t_stop();
    fork
      rx_u.send_ctrl(16'h0BB8, 16'h0000);
      begin
        @(negedge mclk);
        stop = 1'b1;
      end
    join
    stop = 1'b0;
    check(vin_code, 15'h0FA0);
    check(xfer_active, 1'b0);
    check(power_en, 1'b0);
    rx_u.send_ctrl(16'h0BB8, 16'h0000);
    check(vin_code, 15'h0FA0);
    $display("test stop done");
  endtask
  // silent receiver: nine bursts of twenty cycles each, voltage climbing per retry
  task automatic t_retry();
    int pings = 0;
    int on_cyc = 0;
    logic was_on = 1'b0;
    answer_en = 1'b0;
    kick();
    repeat (400) begin
      if (power_en === 1'b1 && was_on !== 1'b1) begin
        check(vin_code, 15'h1B58 + 15'h03E8 * 15'(pings));
        pings++;
      end
      if (power_en === 1'b1) on_cyc++;
      was_on = power_en;
      if (ping_fail === 1'b1) break;
      @(negedge mclk);
    end
    check(pings, 32'h9);
    check(on_cyc, 32'hB4);
    check(power_en, 1'b0);
    check(ping_fail, 1'b1);
    $display("test retry done");
  endtask
  // too weak a reply counts as none; the least acceptable value then wins
  task automatic t_reject();
    answer_en = 1'b1;
    answer_val = 8'h00;
    kick();
    check(ping_fail, 1'b0);
    repeat (60) if (vin_code !== 15'h1F40 || power_en !== 1'b1) @(negedge mclk);
    answer_val = 8'h01;
    check(vin_code, 15'h1F40);
    check(xfer_active, 1'b0);
    repeat (40) if (xfer_active !== 1'b1) @(negedge mclk);
    check(xfer_active, 1'b1);
    check(vin_code, 15'h1F40);
    $display("test reject done");
  endtask
  // reset in the middle of a transfer must drop power and restore the ping point
  task automatic t_mid_reset();
    check(xfer_active, 1'b1);
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    stop = 1'b0;
    answer_en = 1'b1;
    answer_val = 8'h40;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_xfer();
    t_stop();
    t_retry();
    t_reject();
    t_mid_reset();
    final_report();
  end
  // the run needs about 400 cycles; 4000 leaves ample margin
  initial begin
    #40000;
    fail_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule
`default_nettype wire
